// >>> npic_consts.svh
// constants of the nested priority interrupt controller
`ifndef NPIC_CONSTS_SVH
`define NPIC_CONSTS_SVH
`define NPIC_IDX_VPRIO0   8'h24
`define NPIC_IDX_VPRIO1   8'h25
`define NPIC_IDX_VPRIO2   8'h26
`define NPIC_IDX_VPRIO3   8'h27
`define NPIC_IDX_EXTCTL   8'h28
`define NPIC_IDX_STATUS   8'h29
`define NPIC_VPRIO_RST    8'hff
`define NPIC_VPRIO3_RO    4'hf
`define NPIC_EXTCTL_RST   8'h00
`define NPIC_CCR_UPPER    5
`define NPIC_CCR_LOWER    3
`define NPIC_CODE_L0      2'b10
`define NPIC_CODE_L3      2'b11
`define NPIC_VEC_SRC0     16'hfffa
`define NPIC_PERIPH_MASK  14'h3f82
`define NPIC_WAKE_FIXED   14'h003f
`define NPIC_SRC_SPI      7
`define NPIC_SRC_PWM      13
`define NPIC_SRC_EXT0     4'h2
`define NPIC_ST_REQ       8
`define NPIC_ST_SRC       12
`endif

// >>> npic_pkg.sv
// types shared by the nested priority interrupt controller
package npic_pkg;
   typedef logic [1:0] npic_code_t;
   typedef logic [1:0] npic_lvl_t;
   typedef enum logic [1:0] {
      NPIC_APB_IDLE = 2'b01,
      NPIC_APB_ACC  = 2'b10
   } npic_apb_t;
   // code to numeric level: 10->0, 01->1, 00->2, 11->3
   function automatic npic_lvl_t npic_level(input npic_code_t code);
      return {~(code[1] ^ code[0]), code[0]};
   endfunction
endpackage

// >>> npic_ext_line.sv
// one external interrupt line: pin group, sensitivity and edge latch
`timescale 1ns/10ps
module npic_ext_line #(parameter int N = 4) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [N-1:0] pins,
   input  wire logic [1:0]   sense,
   input  wire logic         invert,
   input  wire logic         clear,
   output logic              pending
);
   logic [N-1:0] prev;
   logic [N-1:0] rise;
   logic [N-1:0] fall;
   logic         hit;
   logic         level_on;
   logic         edge_lat;

   // idle-high reset value avoids a false rising edge after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= '1;
      end else begin
         prev <= pins;
      end
   end

   assign rise = pins & ~prev;
   assign fall = prev & ~pins;

   // pins of the group are ORed
   always_comb begin
      hit      = 1'b0;
      level_on = 1'b0;
      case (sense)
         2'b00: begin
            hit      = invert ? |rise : |fall;
            level_on = invert ? |pins : |(~pins);
         end
         2'b01: hit = invert ? |fall : |rise;
         2'b10: hit = invert ? |rise : |fall;
         default: hit = |(rise | fall);
      endcase
   end

   // new edge wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_lat <= 1'b0;
      end else if (hit) begin
         edge_lat <= 1'b1;
      end else if (clear) begin
         edge_lat <= 1'b0;
      end
   end

   assign pending = edge_lat | level_on;
endmodule

// >>> npic_arb.sv
// selection of the pending request to service
`timescale 1ns/10ps
module npic_arb
   import npic_pkg::*;
(
   input  wire logic [13:0] pend,
   input  wire logic [27:0] prio_flat,
   input  wire npic_lvl_t   cur_lvl,
   input  wire logic        halted,
   input  wire logic [13:0] wake_cap,
   output logic             found,
   output logic [3:0]       src
);
   logic [2:0] best;
   logic [2:0] lv;

   // walk low hardware priority upward so ties end on the lower number
   always_comb begin
      found = 1'b0;
      src   = 4'h0;
      best  = 3'h0;
      lv    = 3'h0;
      for (int i = 13; i >= 0; i--) begin
         // source 0 stands above level 3
         lv = (i == 0) ? 3'h4 : {1'b0, npic_level(prio_flat[2*i +: 2])};
         if (pend[i] && (!halted || wake_cap[i]) && lv > {1'b0, cur_lvl}
             && (!found || lv >= best)) begin
            found = 1'b1;
            src   = 4'(i);
            best  = lv;
         end
      end
   end
endmodule

// >>> npic_top.sv
// nested priority interrupt controller with apb register access
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "npic_consts.svh"
module npic_top
   import npic_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RESET_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        ENABLE_IRQ_INSTR,
   input  wire logic        DISABLE_IRQ_INSTR,
   input  wire logic        HALT_INSTR,
   input  wire logic        WAIT_IRQ_INSTR,
   input  wire logic        TRAP_INSTR,
   input  wire logic        IRQ_RETURN_INSTR,
   input  wire logic        POP_COND_INSTR,
   input  wire logic [7:0]  CONDITION_CODE_REG,
   input  wire logic        CPU_HALTED,
   input  wire logic        IRQ_ACK,
   input  wire logic        TOP_LEVEL_IRQ_PIN,
   input  wire logic [3:0]  PORTA_PINS,
   input  wire logic [2:0]  PORTF_PINS,
   input  wire logic [7:0]  PORTB_PINS,
   input  wire logic [13:0] PERIPH_IRQ,
   input  wire logic        SPI_SLAVE,
   input  wire logic        PWM_EXT_CLK,
   output logic             IRQ_REQ,
   output logic      [3:0]  IRQ_SOURCE,
   output logic      [15:0] IRQ_VECTOR,
   output logic             CUR_PRIO_UPPER,
   output logic             CUR_PRIO_LOWER,
   output logic             BRANCH_IF_MASKED,
   output logic             BRANCH_IF_UNMASKED,
   output logic             WAKE_REQ
);
   // ****************************************
   // declarations
   // ****************************************
   npic_apb_t   apb_st;
   logic [7:0]  vector_priority_regs [0:3];
   logic [7:0]  ext_irq_control_reg;
   npic_code_t  cur_prio;
   npic_code_t  next_prio;
   npic_code_t  field [0:13];
   logic [27:0] prio_flat;
   npic_code_t  ack_field;
   logic        apb_wr;
   logic [3:0]  sel_vprio;
   logic        sel_extctl;
   logic        sel_status;
   logic        mapped;
   logic [31:0] rdata;
   logic        ext_chg;
   logic        take;
   logic [3:0]  ext_pend;
   logic [3:0]  ext_clr;
   logic        top_irq_raw;
   logic [13:0] pend;
   logic [13:0] wake_cap;
   logic        arb_found;
   logic [3:0]  arb_src;

   // ****************************************
   // apb slave
   // ****************************************
   assign apb_wr = PSEL & PENABLE & PWRITE & PREADY;

   always_comb begin
      sel_vprio  = 4'h0;
      sel_extctl = 1'b0;
      sel_status = 1'b0;
      mapped     = 1'b1;
      if (PADDR == {2'b00, `NPIC_IDX_VPRIO0, 2'b00}) begin
         sel_vprio[0] = 1'b1;
      end else if (PADDR == {2'b00, `NPIC_IDX_VPRIO1, 2'b00}) begin
         sel_vprio[1] = 1'b1;
      end else if (PADDR == {2'b00, `NPIC_IDX_VPRIO2, 2'b00}) begin
         sel_vprio[2] = 1'b1;
      end else if (PADDR == {2'b00, `NPIC_IDX_VPRIO3, 2'b00}) begin
         sel_vprio[3] = 1'b1;
      end else if (PADDR == {2'b00, `NPIC_IDX_EXTCTL, 2'b00}) begin
         sel_extctl = 1'b1;
      end else if (PADDR == {2'b00, `NPIC_IDX_STATUS, 2'b00}) begin
         sel_status = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      for (int r = 0; r < 4; r++) begin
         if (sel_vprio[r]) begin
            rdata[7:0] = vector_priority_regs[r];
         end
      end
      if (sel_extctl) begin
         rdata[7:0] = ext_irq_control_reg;
      end
      if (sel_status) begin
         rdata[`NPIC_CCR_UPPER]          = cur_prio[1];
         rdata[`NPIC_CCR_LOWER]          = cur_prio[0];
         rdata[`NPIC_ST_REQ]             = IRQ_REQ;
         rdata[`NPIC_ST_SRC +: 4]        = IRQ_SOURCE;
      end
   end

   // zero wait states: ready rises in the first access cycle
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         apb_st  <= NPIC_APB_IDLE;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end else begin
         case (apb_st)
            NPIC_APB_IDLE: begin
               if (PSEL && !PENABLE) begin
                  apb_st  <= NPIC_APB_ACC;
                  PREADY  <= 1'b1;
                  PSLVERR <= ~mapped;
                  PRDATA  <= rdata;
               end
            end
            default: begin
               apb_st  <= NPIC_APB_IDLE;
               PREADY  <= 1'b0;
               PSLVERR <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // vector priority registers
   // ****************************************
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int r = 0; r < 4; r++) begin
            vector_priority_regs[r] <= `NPIC_VPRIO_RST;
         end
      end else if (apb_wr) begin
         for (int r = 0; r < 4; r++) begin
            for (int f = 0; f < 4; f++) begin
               // upper half of the last register stays read-only
               if (sel_vprio[r] && !(r == 3 && f >= 2)
                   && PWDATA[2*f +: 2] != `NPIC_CODE_L0) begin
                  vector_priority_regs[r][2*f +: 2] <= PWDATA[2*f +: 2];
               end
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 14; i++) begin
         field[i]           = vector_priority_regs[i/4][2*(i%4) +: 2];
         prio_flat[2*i +: 2] = field[i];
      end
   end

   // ****************************************
   // external control register
   // ****************************************
   // sensitivity writes outside level 3 are dropped, not queued
   assign ext_chg = apb_wr && sel_extctl && cur_prio == `NPIC_CODE_L3
                    && PWDATA[7:2] != ext_irq_control_reg[7:2];

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ext_irq_control_reg <= `NPIC_EXTCTL_RST;
      end else if (apb_wr && sel_extctl) begin
         if (cur_prio == `NPIC_CODE_L3) begin
            ext_irq_control_reg[7:2] <= PWDATA[7:2];
         end
         if (!ext_irq_control_reg[0]) begin
            ext_irq_control_reg[1] <= PWDATA[1];
         end
         ext_irq_control_reg[0] <= PWDATA[0];
      end
   end

   // ****************************************
   // external lines
   // ****************************************
   assign take = IRQ_ACK & IRQ_REQ;

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         ext_clr[k] = ext_chg | (take && IRQ_SOURCE == `NPIC_SRC_EXT0 + 4'(k));
      end
   end

   // only the port a low and port b low lines see the polarity bit
   npic_ext_line #(.N(4)) u_ext_line_porta_low (
      .clk     (SYS_CLK),
      .rst_n   (RESET_N),
      .pins    (PORTA_PINS),
      .sense   (ext_irq_control_reg[4:3]),
      .invert  (ext_irq_control_reg[2]),
      .clear   (ext_clr[0]),
      .pending (ext_pend[0])
   );
   npic_ext_line #(.N(3)) u_ext_line_portf_low (
      .clk     (SYS_CLK),
      .rst_n   (RESET_N),
      .pins    (PORTF_PINS),
      .sense   (ext_irq_control_reg[4:3]),
      .invert  (1'b0),
      .clear   (ext_clr[1]),
      .pending (ext_pend[1])
   );
   npic_ext_line #(.N(4)) u_ext_line_portb_low (
      .clk     (SYS_CLK),
      .rst_n   (RESET_N),
      .pins    (PORTB_PINS[3:0]),
      .sense   (ext_irq_control_reg[7:6]),
      .invert  (ext_irq_control_reg[5]),
      .clear   (ext_clr[2]),
      .pending (ext_pend[2])
   );
   npic_ext_line #(.N(4)) u_ext_line_portb_high (
      .clk     (SYS_CLK),
      .rst_n   (RESET_N),
      .pins    (PORTB_PINS[7:4]),
      .sense   (ext_irq_control_reg[7:6]),
      .invert  (1'b0),
      .clear   (ext_clr[3]),
      .pending (ext_pend[3])
   );
   // top-level pin: single edge chosen by bit 1
   npic_ext_line #(.N(1)) u_top_level_irq (
      .clk     (SYS_CLK),
      .rst_n   (RESET_N),
      .pins    (TOP_LEVEL_IRQ_PIN),
      .sense   (ext_irq_control_reg[1] ? 2'b01 : 2'b10),
      .invert  (1'b0),
      .clear   ((take && IRQ_SOURCE == 4'h0) || !ext_irq_control_reg[0]),
      .pending (top_irq_raw)
   );

   // ****************************************
   // arbitration and service request
   // ****************************************
   // source 6 is unused and stays zero
   assign pend = (PERIPH_IRQ & `NPIC_PERIPH_MASK)
                 | {8'h00, ext_pend, 1'b0, top_irq_raw & ext_irq_control_reg[0]};

   always_comb begin
      wake_cap                = `NPIC_WAKE_FIXED;
      wake_cap[`NPIC_SRC_SPI] = SPI_SLAVE;
      wake_cap[`NPIC_SRC_PWM] = PWM_EXT_CLK;
   end

   // field 0 is never consulted by the arbiter
   npic_arb u_arb (
      .pend      (pend),
      .prio_flat (prio_flat),
      .cur_lvl   (npic_level(cur_prio)),
      .halted    (CPU_HALTED),
      .wake_cap  (wake_cap),
      .found     (arb_found),
      .src       (arb_src)
   );

   // request drops for one cycle after a take so the new level settles
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         IRQ_REQ    <= 1'b0;
         IRQ_SOURCE <= 4'h0;
         IRQ_VECTOR <= `NPIC_VEC_SRC0;
         WAKE_REQ   <= 1'b0;
      end else begin
         IRQ_REQ    <= arb_found & ~take;
         IRQ_SOURCE <= arb_src;
         IRQ_VECTOR <= `NPIC_VEC_SRC0 - {11'h000, arb_src, 1'b0};
         WAKE_REQ   <= |(pend & wake_cap);
      end
   end

   // ****************************************
   // current software priority
   // ****************************************
   assign ack_field = field[IRQ_SOURCE];

   always_comb begin
      next_prio = cur_prio;
      if (take) begin
         // a raised field re-enters through the normal compare
         next_prio = (IRQ_SOURCE == 4'h0) ? `NPIC_CODE_L3 : ack_field;
      end else if (IRQ_RETURN_INSTR || POP_COND_INSTR) begin
         next_prio = {CONDITION_CODE_REG[`NPIC_CCR_UPPER],
                      CONDITION_CODE_REG[`NPIC_CCR_LOWER]};
      end else if (ENABLE_IRQ_INSTR || HALT_INSTR || WAIT_IRQ_INSTR) begin
         next_prio = `NPIC_CODE_L0;
      end else if (DISABLE_IRQ_INSTR || TRAP_INSTR) begin
         next_prio = `NPIC_CODE_L3;
      end
   end

   // reset runs at level 3
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cur_prio           <= `NPIC_CODE_L3;
         CUR_PRIO_UPPER     <= 1'b1;
         CUR_PRIO_LOWER     <= 1'b1;
         BRANCH_IF_MASKED   <= 1'b1;
         BRANCH_IF_UNMASKED <= 1'b0;
      end else begin
         cur_prio           <= next_prio;
         CUR_PRIO_UPPER     <= next_prio[1];
         CUR_PRIO_LOWER     <= next_prio[0];
         BRANCH_IF_MASKED   <= (next_prio == `NPIC_CODE_L3);
         BRANCH_IF_UNMASKED <= (next_prio != `NPIC_CODE_L3);
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   property p_entry_load;
      take && IRQ_SOURCE != 4'h0 |=> cur_prio == $past(ack_field);
   endproperty
   a_entry_load: assert property (p_entry_load) else $error("entry level wrong");

   property p_top_level3;
      take && IRQ_SOURCE == 4'h0 |=> CUR_PRIO_UPPER && CUR_PRIO_LOWER;
   endproperty
   a_top_level3: assert property (p_top_level3) else $error("top entry not level 3");

   property p_enable_l0;
      !take && !IRQ_RETURN_INSTR && !POP_COND_INSTR && ENABLE_IRQ_INSTR
         |=> {CUR_PRIO_UPPER, CUR_PRIO_LOWER} == 2'b10;
   endproperty
   a_enable_l0: assert property (p_enable_l0) else $error("enable not level 0");

   property p_disable_l3;
      !take && !IRQ_RETURN_INSTR && !POP_COND_INSTR && !ENABLE_IRQ_INSTR && !HALT_INSTR
         && !WAIT_IRQ_INSTR && DISABLE_IRQ_INSTR |=> BRANCH_IF_MASKED;
   endproperty
   a_disable_l3: assert property (p_disable_l3) else $error("disable not level 3");

   property p_pop_restore;
      !take && POP_COND_INSTR
         |=> cur_prio == {$past(CONDITION_CODE_REG[5]), $past(CONDITION_CODE_REG[3])};
   endproperty
   a_pop_restore: assert property (p_pop_restore) else $error("pop restore wrong");

   property p_branch;
      BRANCH_IF_MASKED == (cur_prio == 2'b11) && BRANCH_IF_UNMASKED != BRANCH_IF_MASKED;
   endproperty
   a_branch: assert property (p_branch) else $error("branch flags wrong");

   property p_hold;
      !take && !IRQ_RETURN_INSTR && !POP_COND_INSTR && !ENABLE_IRQ_INSTR && !HALT_INSTR
         && !WAIT_IRQ_INSTR && !DISABLE_IRQ_INSTR && !TRAP_INSTR |=> $stable(cur_prio);
   endproperty
   a_hold: assert property (p_hold) else $error("priority changed alone");

   property p_level0_kept;
      apb_wr && sel_vprio[0] && PWDATA[5:4] == 2'b10 |=> $stable(vector_priority_regs[0][5:4]);
   endproperty
   a_level0_kept: assert property (p_level0_kept) else $error("level 0 was stored");

   property p_ro_nibble;
      vector_priority_regs[3][7:4] == 4'hf;
   endproperty
   a_ro_nibble: assert property (p_ro_nibble) else $error("read-only bits changed");

   property p_above_current;
      arb_found && arb_src != 4'h0 |-> npic_level(field[arb_src]) > npic_level(cur_prio);
   endproperty
   a_above_current: assert property (p_above_current) else $error("request not above");

   c_nested_entry: cover property (take ##[1:20] take);
   c_top_entry: cover property (take && IRQ_SOURCE == 4'h0);
   c_ext_change: cover property (ext_chg);
   c_wake: cover property (CPU_HALTED && WAKE_REQ);
endmodule

// >>> npic_core_model.sv
// core side model: takes a request after a settable number of cycles
`timescale 1ns/10ps
module npic_core_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       irq_req,
   input  wire logic       ack_en,
   input  wire logic [3:0] dly,
   output logic            irq_ack
);
   // ****************
   // take handshake
   // ****************
   logic [3:0] cnt;
   // one-cycle pulse, never twice in a row, so no double take
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt     <= 4'h0;
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= irq_req && ack_en && !irq_ack && (cnt >= dly);
         cnt     <= (irq_req && !irq_ack && cnt != 4'hf) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule

// >>> tb.sv
// testbench of the nested priority interrupt controller
`timescale 1ns/10ps
`include "npic_consts.svh"
module tb;
   // ****************
   // signals
   // ****************
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [6:0]  instr;
   logic [7:0]  cond;
   logic        halted, ack, ack_en, spi_s, pwm_x, req, up, lo, msk, umsk, wake, top_pin;
   logic [3:0]  dly, porta, src;
   logic [13:0] periph;
   logic [15:0] vec;
   int          bad_count, checks, i, s;
   int          ik[7] = '{0, 1, 6, 4, 2, 1, 3};
   logic [1:0]  ex[7] = '{2'b10, 2'b11, 2'b01, 2'b11, 2'b10, 2'b11, 2'b10};
   int          ws[3] = '{7, 13, 8};

   npic_top i_npic_top (.SYS_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .ENABLE_IRQ_INSTR(instr[0]), .DISABLE_IRQ_INSTR(instr[1]),
      .HALT_INSTR(instr[2]), .WAIT_IRQ_INSTR(instr[3]), .TRAP_INSTR(instr[4]),
      .IRQ_RETURN_INSTR(instr[5]), .POP_COND_INSTR(instr[6]), .CONDITION_CODE_REG(cond),
      .CPU_HALTED(halted), .IRQ_ACK(ack), .TOP_LEVEL_IRQ_PIN(top_pin), .PORTA_PINS(porta),
      .PORTF_PINS(3'h7), .PORTB_PINS(8'hff), .PERIPH_IRQ(periph), .SPI_SLAVE(spi_s),
      .PWM_EXT_CLK(pwm_x), .IRQ_REQ(req), .IRQ_SOURCE(src), .IRQ_VECTOR(vec),
      .CUR_PRIO_UPPER(up), .CUR_PRIO_LOWER(lo), .BRANCH_IF_MASKED(msk),
      .BRANCH_IF_UNMASKED(umsk), .WAKE_REQ(wake));
   npic_core_model i_npic_core_model (.clk(clk), .rst_n(rst_n), .irq_req(req),
      .ack_en(ack_en), .dly(dly), .irq_ack(ack));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ****************
   // tasks
   // ****************
   task stop_test;
      $display("counts: %0d compares, %0d mismatches", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checks++;
      if (g !== x) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask
   task fail_wait(input string n);
      bad_count++;
      $display("MISMATCH %s expected done seen timeout", n);
      stop_test;
   endtask
   // request held until pready is sampled high
   task apb(input logic w, input logic [7:0] x, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {2'b00, x, 2'b00}; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fail_wait("pready");
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] x, input logic [31:0] d);
      apb(1'b1, x, d);
   endtask
   task rd(input logic [7:0] x, input logic [31:0] v, input logic ev);
      apb(1'b0, x, 32'h0);
      chk("prdata", v, r);
      chk("pslverr", {31'h0, ev}, {31'h0, e});
   endtask
   task cycles(input int n);
      repeat (n) @(negedge clk);
   endtask
   task pulse(input int k);
      @(posedge clk) instr[k] <= 1'b1;
      @(posedge clk) instr[k] <= 1'b0;
      @(negedge clk);
   endtask
   task wait_req;
      int n;
      for (n = 0; n < 20 && req !== 1'b1; n++) @(negedge clk);
      if (req !== 1'b1) fail_wait("irq_req");
   endtask
   task wait_code(input logic [1:0] c);
      int n;
      for (n = 0; n < 30 && {up, lo} !== c; n++) @(negedge clk);
      if ({up, lo} !== c) fail_wait("cur_prio");
   endtask
   task end_test(input string n);
      $display("test %s finished, %0d mismatches so far", n, bad_count);
   endtask
   // ****************
   // sequence
   // ****************
   initial begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
      instr = 7'h0; cond = 8'h08; halted = 1'b0; ack_en = 1'b0; dly = 4'h0; spi_s = 1'b0;
      pwm_x = 1'b0; porta = 4'hf; periph = 14'h0; bad_count = 0; checks = 0; top_pin = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 4; i++) rd(8'(`NPIC_IDX_VPRIO0 + i), 32'hff, 1'b0);
      rd(`NPIC_IDX_EXTCTL, 32'h0, 1'b0);
      rd(`NPIC_IDX_STATUS, 32'h28, 1'b0);
      rd(8'h30, 32'h0, 1'b1);
      end_test("reset");
      wr(`NPIC_IDX_VPRIO0, 32'hcf);
      wr(`NPIC_IDX_VPRIO0, 32'h64);
      rd(`NPIC_IDX_VPRIO0, 32'h44, 1'b0);
      wr(`NPIC_IDX_VPRIO3, 32'h00);
      rd(`NPIC_IDX_VPRIO3, 32'hf0, 1'b0);
      wr(`NPIC_IDX_VPRIO2, 32'h00);
      wr(`NPIC_IDX_EXTCTL, 32'h10);
      rd(`NPIC_IDX_EXTCTL, 32'h10, 1'b0);
      end_test("fields");
      for (i = 0; i < 7; i++) begin
         pulse(ik[i]);
         chk("cur_prio", ex[i], {up, lo});
         chk("branch", {ex[i] == 2'b11, ex[i] != 2'b11}, {msk, umsk});
      end
      end_test("instructions");
      pulse(1);
      @(posedge clk) periph <= 14'h0002;
      cycles(4);
      chk("irq_req", 1'b0, req);
      pulse(0);
      wait_req;
      chk("irq_source", 4'h1, src);
      chk("irq_vector", 16'hfff8, vec);
      chk("wake_req", 1'b1, wake);
      @(posedge clk) periph <= 14'h0302;
      cycles(3);
      chk("irq_source", 4'h8, src);
      chk("irq_vector", 16'hffea, vec);
      @(posedge clk) halted <= 1'b1;
      cycles(3);
      chk("irq_source", 4'h1, src);
      @(posedge clk) begin
         halted <= 1'b0;
         ack_en <= 1'b1;
         dly <= 4'h3;
      end
      wait_code(2'b00);
      chk("cur_prio", 2'b00, {up, lo});
      // level requests are cleared at the source by the core
      @(posedge clk) periph <= 14'h0202;
      cycles(5);
      chk("irq_req", 1'b0, req);
      @(posedge clk) ack_en <= 1'b0;
      wr(`NPIC_IDX_VPRIO2, 32'h0c);
      wait_req;
      chk("irq_source", 4'h9, src);
      chk("irq_vector", 16'hffe8, vec);
      @(posedge clk) periph <= 14'h0;
      end_test("arbitration");
      @(posedge clk) cond <= 8'h20;
      pulse(5);
      @(posedge clk) porta <= 4'he;
      wait_req;
      chk("irq_source", 4'h2, src);
      chk("irq_vector", 16'hfff6, vec);
      @(posedge clk) ack_en <= 1'b1;
      wait_code(2'b00);
      @(posedge clk) ack_en <= 1'b0;
      pulse(0);
      cycles(4);
      chk("irq_req", 1'b0, req);
      pulse(1);
      @(posedge clk) porta <= 4'hf;
      cycles(2);
      @(posedge clk) porta <= 4'he;
      cycles(2);
      wr(`NPIC_IDX_EXTCTL, 32'h18);
      pulse(0);
      cycles(4);
      chk("irq_req", 1'b0, req);
      end_test("external");
      for (i = 0; i < 3; i++) begin
         s = ws[i];
         @(posedge clk) begin
            halted <= 1'b1;
            periph <= 14'(1) << s;
            spi_s <= 1'b0;
            pwm_x <= 1'b0;
         end
         cycles(3);
         chk("wake_req", 1'b0, wake);
         @(posedge clk) begin
            spi_s <= 1'b1;
            pwm_x <= 1'b1;
         end
         cycles(3);
         chk("wake_req", {31'h0, s != 8}, {31'h0, wake});
      end
      end_test("wake");
      // top-level request seen at level 3 though its field holds level 2
      @(posedge clk) begin
         halted <= 1'b0;
         periph <= 14'h0;
      end
      pulse(1);
      wr(`NPIC_IDX_EXTCTL, 32'h1b);
      @(posedge clk) top_pin <= 1'b1;
      wait_req;
      chk("irq_source", 4'h0, src);
      chk("irq_vector", 16'hfffa, vec);
      pulse(0);
      @(posedge clk) ack_en <= 1'b1;
      wait_code(2'b11);
      chk("cur_prio", 2'b11, {up, lo});
      @(posedge clk) ack_en <= 1'b0;
      cycles(3);
      chk("irq_req", 1'b0, req);
      end_test("top level");
      stop_test;
   end
endmodule
